/* csc_far_model.sv */
`timescale 1ns/1ps
// chipset side: alert line, debug tool and priority agent
module csc_far_model (
   input wire logic i_clk,
   input wire logic i_sys_hot,
   input wire logic i_dbg_go,
   input wire logic i_prio_want,
   input wire logic i_atomic_lock_n,
   input wire logic i_alert_n,
   input wire logic i_alert_oe,
   output logic o_alert_pin_n,
   output logic o_probe_request_n = 1'b1,
   output logic o_prio_own = 1'b0
);
   // open-drain alert line with pull-up, low while either side pulls
   assign o_alert_pin_n = ~(i_sys_hot | (i_alert_oe & ~i_alert_n));
   // debug request held for as long as the tool wants the session
   always @(posedge i_clk) begin
      o_probe_request_n <= ~i_dbg_go;
      // the agent only owns the bus once lock is seen released
      o_prio_own <= i_prio_want & i_atomic_lock_n;
   end
endmodule : csc_far_model

/* csc_int_regs.sv */
`timescale 1ns/1ps
// small integer register file, registered read data
module csc_int_regs #(
   parameter int DEPTH = csc_pkg::INT_REGS,
   parameter int WIDTH = csc_pkg::INT_REG_W,
   parameter int IDX_W = csc_pkg::INT_IDX_W
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_clear,
   input wire logic i_wr_en,
   input wire logic [IDX_W-1:0] i_wr_idx,
   input wire logic [WIDTH-1:0] i_wr_data,
   input wire logic [IDX_W-1:0] i_rd_idx,
   output logic [WIDTH-1:0] o_rd_data
);
   logic [WIDTH-1:0] mem_reg [DEPTH];

   ////////////////////////////////////////////////////////////////////////
   // clear wins over a write in the same cycle so init leaves no stale word
   generate
      for (genvar g = 0; g < DEPTH; g++) begin : g_word
         always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               mem_reg[g] <= csc_pkg::INT_REG_RST;
            end else if (i_clear) begin
               mem_reg[g] <= csc_pkg::INT_REG_RST;
            end else if (i_wr_en && (i_wr_idx == IDX_W'(g))) begin
               mem_reg[g] <= i_wr_data;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // read port
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rd_data <= csc_pkg::INT_REG_RST;
      end else begin
         o_rd_data <= i_clear ? csc_pkg::INT_REG_RST : mem_reg[i_rd_idx];
      end
   end
endmodule : csc_int_regs

/* csc_pkg.sv */
package csc_pkg;
   // widths of the bus lines that the bit-order strap reverses, then local interrupt pin layout (not reversed)
   localparam int DATA_W = 64;
   localparam int ADDR_HI = 31;
   localparam int ADDR_LO = 3;
   localparam int ADDR_W = ADDR_HI - ADDR_LO + 1;
   localparam int DINV_W = 4;
   localparam int LINT_W = 2;
   localparam int LINT_MASKABLE = 0;
   localparam int LINT_NONMASKABLE = 1;
   // integer register file shape
   localparam int INT_REGS = 8;
   localparam int INT_REG_W = 32;
   localparam int INT_IDX_W = 3;
   localparam logic [INT_REG_W-1:0] INT_REG_RST = 32'h0000_0000;
   // reset vector used when nothing else configures one (arbitrary)
   localparam logic [31:0] RESET_VECTOR_DFLT = 32'hffff_fff0;
   // synchroniser depth
   localparam int SYNC_STAGES = 2;

   typedef enum logic [1:0] {
      CSC_LOCK_IDLE,
      CSC_LOCK_HELD
   } csc_lock_e;

   typedef enum logic [1:0] {
      CSC_PROBE_IDLE,
      CSC_PROBE_READY,
      CSC_PROBE_RELEASE
   } csc_probe_e;
endpackage : csc_pkg

/* csc_sideband.sv */
`timescale 1ns/1ps
module csc_sideband #(
   parameter logic [31:0] RESET_VECTOR = csc_pkg::RESET_VECTOR_DFLT
) (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   // soft init, asynchronous, active low
   input wire logic i_soft_init_n,
   // hard reset, used only for the strap sample
   input wire logic i_hard_reset_n,
   // core-side bus lines, before the bit-order strap
   input wire logic [csc_pkg::DATA_W-1:0] i_core_data,
   input wire logic [csc_pkg::ADDR_W-1:0] i_core_addr,
   input wire logic [csc_pkg::DINV_W-1:0] i_core_data_invert_n,
   output logic [csc_pkg::DATA_W-1:0] o_bus_data,
   output logic [csc_pkg::ADDR_W-1:0] o_bus_addr,
   output logic [csc_pkg::DINV_W-1:0] o_bus_data_invert_n,
   output logic o_bit_swap,
   // integer register access from the core
   input wire logic i_int_wr_en,
   input wire logic [csc_pkg::INT_IDX_W-1:0] i_int_wr_idx,
   input wire logic [csc_pkg::INT_REG_W-1:0] i_int_wr_data,
   input wire logic [csc_pkg::INT_IDX_W-1:0] i_int_rd_idx,
   output logic [csc_pkg::INT_REG_W-1:0] o_int_rd_data,
   // instruction fetch restart
   output logic o_fetch_restart,
   output logic [31:0] o_fetch_addr,
   // snoop path
   input wire logic i_snoop_req,
   output logic o_snoop_ack,
   // local interrupt pins and controller state
   input wire logic [csc_pkg::LINT_W-1:0] i_local_irq_pins,
   input wire logic i_irq_ctrl_disable_wr,
   input wire logic i_irq_ctrl_disable_val,
   output logic o_local_irq_controller_en,
   output logic [csc_pkg::LINT_W-1:0] o_local_irq,
   output logic o_maskable_irq,
   output logic o_nonmaskable_irq,
   // atomic lock
   input wire logic i_lock_seq_start,
   input wire logic i_lock_seq_end,
   output logic o_atomic_lock_n,
   // debug probe
   input wire logic i_probe_request_n,
   input wire logic i_probe_done,
   output logic o_probe_ready_n,
   output logic o_debug_mode,
   // thermal
   input wire logic i_temp_max,
   input wire logic i_throttle_enable,
   input wire logic i_thermal_alert_n,
   output logic o_thermal_alert_n,
   output logic o_thermal_alert_oe,
   output logic o_throttle_active
);
   logic rst_meta_reg;
   logic rst_n_reg;
   logic init_sync_n;
   logic init_prev_n_reg;
   logic hard_sync_n;
   logic hard_prev_n_reg;
   logic [csc_pkg::LINT_W-1:0] lint_sync;
   logic probe_request_n_sync_n;
   logic alert_in_sync_n;
   logic irq_en_reg;
   logic swap_reg;
   logic ext_throttle_reg;
   logic [1:0] oe_hist_reg;
   csc_pkg::csc_lock_e lock_reg;
   csc_pkg::csc_probe_e probe_reg;
   logic ext_alert;

   ////////////////////////////////////////////////////////////////////////
   // reset release through two flops; assert is immediate
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg <= rst_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // synchronisers for every pin-level input
   csc_sync #(.WIDTH(3), .RST_VAL(3'h7)) u_sync_n (
      .i_clk(i_clk_sys),
      .i_rst_n(rst_n_reg),
      .i_async({i_soft_init_n, i_probe_request_n, i_thermal_alert_n}),
      .o_sync({init_sync_n, probe_request_n_sync_n, alert_in_sync_n})
   );

   // hard reset level; only its release edge is used, for the strap
   csc_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_sync_hard (
      .i_clk(i_clk_sys),
      .i_rst_n(rst_n_reg),
      .i_async(i_hard_reset_n),
      .o_sync(hard_sync_n)
   );

   csc_sync #(.WIDTH(csc_pkg::LINT_W), .RST_VAL(2'h0)) u_sync_lint (
      .i_clk(i_clk_sys),
      .i_rst_n(rst_n_reg),
      .i_async(i_local_irq_pins),
      .o_sync(lint_sync)
   );

   ////////////////////////////////////////////////////////////////////////
   // edge history for init and hard reset
   always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         init_prev_n_reg <= 1'b1;
         hard_prev_n_reg <= 1'b0;
      end else begin
         init_prev_n_reg <= init_sync_n;
         hard_prev_n_reg <= hard_sync_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // strap caught on the rising edge of hard reset, not under async reset
   always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         swap_reg <= 1'b0;
      end else if (hard_sync_n && !hard_prev_n_reg) begin
         swap_reg <= !init_sync_n;
      end
   end

   // bit-order reversal of data, address and invert lines
   always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         o_bus_data <= '0;
         o_bus_addr <= '0;
         o_bus_data_invert_n <= '1;
      end else if (swap_reg) begin
         o_bus_data <= {<<{i_core_data}};
         o_bus_addr <= {<<{i_core_addr}};
         o_bus_data_invert_n <= {<<{i_core_data_invert_n}};
      end else begin
         o_bus_data <= i_core_data;
         o_bus_addr <= i_core_addr;
         o_bus_data_invert_n <= i_core_data_invert_n;
      end
   end

   assign o_bit_swap = swap_reg;

   ////////////////////////////////////////////////////////////////////////
   // integer registers cleared by soft init; caches and fp live elsewhere
   csc_int_regs u_int_regs (
      .i_clk(i_clk_sys),
      .i_rst_n(rst_n_reg),
      .i_clear(!init_sync_n),
      .i_wr_en(i_int_wr_en),
      .i_wr_idx(i_int_wr_idx),
      .i_wr_data(i_int_wr_data),
      .i_rd_idx(i_int_rd_idx),
      .o_rd_data(o_int_rd_data)
   );

   // fetch restarts once init is released, at the configured vector
   always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         o_fetch_restart <= 1'b0;
         o_fetch_addr <= RESET_VECTOR;
      end else begin
         o_fetch_restart <= init_sync_n && !init_prev_n_reg;
         o_fetch_addr <= RESET_VECTOR;
      end
   end

   // snoops are acked regardless of init, a one-cycle reply
   always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         o_snoop_ack <= 1'b0;
      end else begin
         o_snoop_ack <= i_snoop_req;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // local interrupt controller enable, on by default
   always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         irq_en_reg <= 1'b1;
      end else if (i_irq_ctrl_disable_wr) begin
         irq_en_reg <= !i_irq_ctrl_disable_val;
      end
   end

   // pins go to the controller or become the legacy irq lines
   always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         o_local_irq <= '0;
         o_maskable_irq <= 1'b0;
         o_nonmaskable_irq <= 1'b0;
      end else if (irq_en_reg) begin
         o_local_irq <= lint_sync;
         o_maskable_irq <= 1'b0;
         o_nonmaskable_irq <= 1'b0;
      end else begin
         o_local_irq <= '0;
         o_maskable_irq <= lint_sync[csc_pkg::LINT_MASKABLE];
         o_nonmaskable_irq <= lint_sync[csc_pkg::LINT_NONMASKABLE];
      end
   end

   assign o_local_irq_controller_en = irq_en_reg;

   ////////////////////////////////////////////////////////////////////////
   // lock spans a sequence; end wins if start and end share a cycle
   always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         lock_reg <= csc_pkg::CSC_LOCK_IDLE;
      end else begin
         unique case (lock_reg)
            csc_pkg::CSC_LOCK_IDLE: begin
               if (i_lock_seq_start && !i_lock_seq_end) begin
                  lock_reg <= csc_pkg::CSC_LOCK_HELD;
               end
            end
            csc_pkg::CSC_LOCK_HELD: begin
               if (i_lock_seq_end) begin
                  lock_reg <= csc_pkg::CSC_LOCK_IDLE;
               end
            end
            default: lock_reg <= csc_pkg::CSC_LOCK_IDLE;
         endcase
      end
   end

   // start cycle already shows lock; the partner must wait for release
   assign o_atomic_lock_n = !(i_lock_seq_start ||
      (lock_reg == csc_pkg::CSC_LOCK_HELD));

   ////////////////////////////////////////////////////////////////////////
   // probe handshake: request raises ready until done or the tool lets go
   always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         probe_reg <= csc_pkg::CSC_PROBE_IDLE;
      end else begin
         unique case (probe_reg)
            csc_pkg::CSC_PROBE_IDLE: begin
               if (!probe_request_n_sync_n) begin
                  probe_reg <= csc_pkg::CSC_PROBE_READY;
               end
            end
            csc_pkg::CSC_PROBE_READY: begin
               if (i_probe_done || probe_request_n_sync_n) begin
                  probe_reg <= csc_pkg::CSC_PROBE_RELEASE;
               end
            end
            csc_pkg::CSC_PROBE_RELEASE: begin
               // wait for request release so one request is one session
               if (probe_request_n_sync_n) begin
                  probe_reg <= csc_pkg::CSC_PROBE_IDLE;
               end
            end
            default: probe_reg <= csc_pkg::CSC_PROBE_IDLE;
         endcase
      end
   end

   assign o_probe_ready_n = (probe_reg != csc_pkg::CSC_PROBE_READY);
   assign o_debug_mode = (probe_reg == csc_pkg::CSC_PROBE_READY);

   ////////////////////////////////////////////////////////////////////////
   // thermal alert pin: open-drain style, we only ever pull it low
   always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         o_thermal_alert_oe <= 1'b0;
      end else begin
         o_thermal_alert_oe <= i_temp_max;
      end
   end

   assign o_thermal_alert_n = 1'b0;

   // own drive reaches the synced pin two cycles late, so remember it
   always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         oe_hist_reg <= '0;
      end else begin
         oe_hist_reg <= {oe_hist_reg[0], o_thermal_alert_oe};
      end
   end

   // own drive and its echo must not count as external; an outside
   // alert during our own drive is only seen once the echo has passed
   assign ext_alert = !alert_in_sync_n && !o_thermal_alert_oe &&
      !(|oe_hist_reg);

   // external throttling holds until the pin reads high again
   always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         ext_throttle_reg <= 1'b0;
      end else if (ext_alert && i_throttle_enable) begin
         ext_throttle_reg <= 1'b1;
      end else if (alert_in_sync_n) begin
         ext_throttle_reg <= 1'b0;
      end
   end

   assign o_throttle_active = i_throttle_enable &&
      (o_thermal_alert_oe || ext_throttle_reg);

endmodule : csc_sideband

/* csc_sideband_monitor.sv */
`timescale 1ns/1ps
// port-level checker for the sideband block, core clock only
module csc_sideband_monitor #(
   parameter logic [31:0] RESET_VECTOR = 32'h0
) (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic [csc_pkg::DATA_W-1:0] i_core_data,
   input wire logic [csc_pkg::DATA_W-1:0] o_bus_data,
   input wire logic o_bit_swap,
   input wire logic [csc_pkg::INT_REG_W-1:0] o_int_rd_data,
   input wire logic o_fetch_restart,
   input wire logic [31:0] o_fetch_addr,
   input wire logic i_snoop_req,
   input wire logic o_snoop_ack,
   input wire logic [csc_pkg::LINT_W-1:0] i_local_irq_pins,
   input wire logic o_local_irq_controller_en,
   input wire logic o_maskable_irq,
   input wire logic o_nonmaskable_irq,
   input wire logic i_lock_seq_start,
   input wire logic i_lock_seq_end,
   input wire logic o_atomic_lock_n,
   input wire logic i_probe_request_n,
   input wire logic o_probe_ready_n,
   input wire logic i_temp_max,
   input wire logic i_throttle_enable,
   input wire logic i_thermal_alert_n,
   input wire logic o_thermal_alert_n,
   input wire logic o_thermal_alert_oe,
   input wire logic o_throttle_active
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_arst_n);
   // expected bus data lines once the bit-order strap is set
   function automatic logic [63:0] rev64(input logic [63:0] v);
      for (int k = 0; k < 64; k++) rev64[k] = v[63-k];
   endfunction : rev64
   ////////////////////////////////////////////////////////////////////////////
   AST_LOCK_START: assert property (i_lock_seq_start |-> !o_atomic_lock_n)
      else $error("lock not asserted at sequence start");
   AST_LOCK_HOLD: assert property (!o_atomic_lock_n |=> o_atomic_lock_n == $past(i_lock_seq_end))
      else $error("lock dropped early or held past end");
   AST_ALERT_OUT: assert property (1'b1 |=> o_thermal_alert_oe == $past(i_temp_max) && !o_thermal_alert_n)
      else $error("thermal alert drive does not follow monitor");
   AST_SNOOP: assert property (1'b1 |=> o_snoop_ack == $past(i_snoop_req))
      else $error("snoop not answered");
   AST_SWAP: assert property ($stable(o_bit_swap) |-> o_bus_data == (o_bit_swap ? rev64($past(i_core_data)) : $past(i_core_data)))
      else $error("bus data bit order wrong");
   AST_IRQ: assert property ((!o_local_irq_controller_en && $stable(i_local_irq_pins)) [*4] |-> o_maskable_irq == i_local_irq_pins[0] && o_nonmaskable_irq == i_local_irq_pins[1])
      else $error("local pins not routed as irqs");
   AST_PROBE: assert property ($fell(i_probe_request_n) && o_probe_ready_n |-> ##[1:5] !o_probe_ready_n)
      else $error("probe ready missing");
   AST_THR_SET: assert property ($fell(i_thermal_alert_n) && i_throttle_enable && !o_thermal_alert_oe |-> ##[1:5] o_throttle_active)
      else $error("throttle not started by alert");
   AST_THR_HOLD: assert property (o_throttle_active && !i_thermal_alert_n && !o_thermal_alert_oe |=> o_throttle_active)
      else $error("throttle dropped while alert held");
   AST_THR_CLR: assert property ($rose(i_thermal_alert_n) && !i_temp_max |-> ##[1:5] !o_throttle_active)
      else $error("throttle stuck after alert release");
   AST_FETCH: assert property (o_fetch_restart |-> (o_fetch_addr == RESET_VECTOR && o_int_rd_data == 32'h0) ##1 !o_fetch_restart)
      else $error("fetch restart wrong");
endmodule : csc_sideband_monitor

bind csc_sideband csc_sideband_monitor #(.RESET_VECTOR(RESET_VECTOR)) u_mon (.*);

/* csc_sync.sv */
`timescale 1ns/1ps
// two-flop synchroniser for a group of independent level bits
module csc_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_reg;

   // meta_reg feeds nothing but the second stage
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_reg <= RST_VAL;
         o_sync <= RST_VAL;
      end else begin
         meta_reg <= i_async;
         o_sync <= meta_reg;
      end
   end
endmodule : csc_sync

/* tb_cpu_sideband_control.sv */
`timescale 1ns/1ps
// self-checking bench for the sideband block
module tb_cpu_sideband_control;
   localparam logic [31:0] VEC = 32'h0000_fff0;
   logic i_clk_sys = 1'b0, i_arst_n = 1'b0, i_soft_init_n = 1'b1;
   logic i_hard_reset_n = 1'b0, i_int_wr_en = 1'b0, i_snoop_req = 1'b0;
   logic i_irq_ctrl_disable_wr = 1'b0, i_irq_ctrl_disable_val = 1'b1;
   logic i_lock_seq_start = 1'b0, i_lock_seq_end = 1'b0, i_probe_done = 1'b0;
   logic i_temp_max = 1'b0, i_throttle_enable = 1'b0;
   logic [63:0] i_core_data = 64'h0, o_bus_data;
   logic [28:0] i_core_addr = 29'h0, o_bus_addr;
   logic [3:0] i_core_data_invert_n = 4'h5, o_bus_data_invert_n;
   logic [2:0] i_int_wr_idx = 3'h0, i_int_rd_idx = 3'h0;
   logic [31:0] i_int_wr_data = 32'h0, o_int_rd_data, o_fetch_addr;
   logic [1:0] i_local_irq_pins = 2'h0, o_local_irq;
   logic o_bit_swap, o_fetch_restart, o_snoop_ack, o_local_irq_controller_en;
   logic o_maskable_irq, o_nonmaskable_irq, o_atomic_lock_n, o_probe_ready_n;
   logic o_debug_mode, o_thermal_alert_n, o_thermal_alert_oe;
   logic o_throttle_active, i_probe_request_n, i_thermal_alert_n, prio_own;
   logic sys_hot = 1'b0, dbg_go = 1'b0, prio_want = 1'b0;
   int err_count = 0, comparisons = 0;
   always #4 i_clk_sys = ~i_clk_sys;
   csc_sideband #(.RESET_VECTOR(VEC)) dut_u (.*);
   csc_far_model u_far (.i_clk(i_clk_sys), .i_sys_hot(sys_hot),
      .i_dbg_go(dbg_go), .i_prio_want(prio_want),
      .i_atomic_lock_n(o_atomic_lock_n), .i_alert_n(o_thermal_alert_n),
      .i_alert_oe(o_thermal_alert_oe), .o_alert_pin_n(i_thermal_alert_n),
      .o_probe_request_n(i_probe_request_n), .o_prio_own(prio_own));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [63:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask : cyc
   // one edge, then let its updates land before looking
   task automatic step();
      @(posedge i_clk_sys);
      #1;
   endtask : step
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : close_out
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      #1 chk("ctrl_en", o_local_irq_controller_en, 1'b1);
      chk("lock_n", o_atomic_lock_n, 1'b1);
      chk("probe_ready_n_n", o_probe_ready_n, 1'b1);
      chk("swap", o_bit_swap, 1'b0);
   endtask : t_reset
   // a written register is wiped by soft init, snoops carry on
   task automatic t_init();
      cyc(1);
      i_int_wr_en <= 1'b1;
      i_int_wr_idx <= 3'h5;
      i_int_wr_data <= 32'hdead_0042;
      i_core_data <= 64'h3;
      cyc(1);
      i_int_wr_en <= 1'b0;
      i_int_rd_idx <= 3'h5;
      cyc(2);
      #1 chk("reg5", o_int_rd_data, 32'hdead_0042);
      chk("bus", o_bus_data, 64'h3);
      cyc(1);
      i_soft_init_n <= 1'b0;
      i_snoop_req <= 1'b1;
      cyc(6);
      #1 chk("snoop", o_snoop_ack, 1'b1);
      cyc(1);
      i_soft_init_n <= 1'b1;
      i_snoop_req <= 1'b0;
      for (int k = 0; k < 8 && o_fetch_restart !== 1'b1; k++) step();
      chk("restart", o_fetch_restart, 1'b1);
      chk("fetch", o_fetch_addr, VEC);
      step();
      chk("reg5_clr", o_int_rd_data, 32'h0);
   endtask : t_init
   task automatic t_irq();
      cyc(1);
      i_irq_ctrl_disable_wr <= 1'b1;
      cyc(1);
      i_irq_ctrl_disable_wr <= 1'b0;
      i_local_irq_pins <= 2'h1;
      cyc(5);
      #1 chk("ctrl_en", o_local_irq_controller_en, 1'b0);
      chk("irq", {o_nonmaskable_irq, o_maskable_irq}, 2'h1);
      cyc(1);
      i_local_irq_pins <= 2'h2;
      cyc(5);
      #1 chk("irq", {o_nonmaskable_irq, o_maskable_irq}, 2'h2);
      cyc(1);
      i_irq_ctrl_disable_wr <= 1'b1;
      i_irq_ctrl_disable_val <= 1'b0;
      cyc(1);
      i_irq_ctrl_disable_wr <= 1'b0;
      cyc(5);
      #1 chk("lint", o_local_irq, 2'h2);
      chk("irq", {o_nonmaskable_irq, o_maskable_irq}, 2'h0);
   endtask : t_irq
   // agent wants the bus during a locked sequence and must wait
   task automatic t_lock();
      cyc(1);
      prio_want <= 1'b1;
      i_lock_seq_start <= 1'b1;
      #1 chk("lock_n", o_atomic_lock_n, 1'b0);
      cyc(1);
      i_lock_seq_start <= 1'b0;
      cyc(4);
      #1 chk("lock_n", o_atomic_lock_n, 1'b0);
      chk("own", prio_own, 1'b0);
      cyc(1);
      i_lock_seq_end <= 1'b1;
      cyc(1);
      i_lock_seq_end <= 1'b0;
      #1 chk("lock_n", o_atomic_lock_n, 1'b1);
      cyc(2);
      #1 chk("own", prio_own, 1'b1);
   endtask : t_lock
   task automatic t_probe();
      cyc(1);
      dbg_go <= 1'b1;
      for (int k = 0; k < 8 && o_probe_ready_n !== 1'b0; k++) step();
      chk("probe_ready_n_n", o_probe_ready_n, 1'b0);
      chk("debug", o_debug_mode, 1'b1);
      cyc(1);
      dbg_go <= 1'b0;
      for (int k = 0; k < 8 && o_probe_ready_n !== 1'b1; k++) step();
      chk("probe_ready_n_n", o_probe_ready_n, 1'b1);
      // second session ended by done while the request still stands
      cyc(1);
      dbg_go <= 1'b1;
      for (int k = 0; k < 8 && o_probe_ready_n !== 1'b0; k++) step();
      chk("probe_ready_n_n", o_probe_ready_n, 1'b0);
      cyc(1);
      i_probe_done <= 1'b1;
      cyc(1);
      i_probe_done <= 1'b0;
      #1 chk("probe_ready_n_n", o_probe_ready_n, 1'b1);
      cyc(4);
      #1 chk("probe_ready_n_n", o_probe_ready_n, 1'b1);
      cyc(1);
      dbg_go <= 1'b0;
      cyc(6);
   endtask : t_probe
   // own alert, external alert while disabled, then enabled and held
   task automatic t_thermal();
      cyc(1);
      i_temp_max <= 1'b1;
      cyc(2);
      #1 chk("pin", i_thermal_alert_n, 1'b0);
      cyc(1);
      i_temp_max <= 1'b0;
      sys_hot <= 1'b1;
      cyc(6);
      #1 chk("thr", o_throttle_active, 1'b0);
      cyc(1);
      sys_hot <= 1'b0;
      cyc(4);
      i_throttle_enable <= 1'b1;
      sys_hot <= 1'b1;
      for (int k = 0; k < 8 && o_throttle_active !== 1'b1; k++) step();
      chk("thr", o_throttle_active, 1'b1);
      cyc(8);
      #1 chk("thr", o_throttle_active, 1'b1);
      cyc(1);
      sys_hot <= 1'b0;
      for (int k = 0; k < 8 && o_throttle_active !== 1'b0; k++) step();
      chk("thr", o_throttle_active, 1'b0);
   endtask : t_thermal
   // init held low across hard reset release sets the bit-order swap
   task automatic t_strap();
      cyc(1);
      i_hard_reset_n <= 1'b0;
      i_soft_init_n <= 1'b0;
      cyc(4);
      i_hard_reset_n <= 1'b1;
      cyc(4);
      i_soft_init_n <= 1'b1;
      i_core_data <= 64'h1;
      i_core_addr <= 29'h3;
      cyc(6);
      #1 chk("swap", o_bit_swap, 1'b1);
      chk("bus", o_bus_data, 64'h8000_0000_0000_0000);
      chk("addr", o_bus_addr, 29'h1800_0000);
      chk("dinv", o_bus_data_invert_n, 4'ha);
   endtask : t_strap
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(8);
      i_arst_n <= 1'b1;
      i_hard_reset_n <= 1'b1;
      cyc(4);
      t_reset();
      t_init();
      t_irq();
      t_lock();
      t_probe();
      t_thermal();
      t_strap();
      close_out();
   end
   // the whole sequence needs about 130 cycles
   initial begin
      repeat (2000) @(posedge i_clk_sys);
      err_count++;
      close_out();
   end
endmodule : tb_cpu_sideband_control
